// ### rtl/adcr_pkg.sv
// Purpose: Constants and types for the converter control and result registers
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Register offsets are word aligned
package adcr_pkg;
    localparam logic [4:0] ADCR_OFS_RES_HI = 5'h00;
    localparam logic [4:0] ADCR_OFS_RES_LO = 5'h04;
    localparam logic [4:0] ADCR_OFS_CTRL0 = 5'h08;
    localparam logic [4:0] ADCR_OFS_CTRL1 = 5'h0C;
    localparam logic [4:0] ADCR_OFS_BGAP = 5'h10;
    localparam logic [7:0] ADCR_CTRL0_RST = 8'h00;
    localparam logic [7:0] ADCR_CTRL1_RST = 8'h00;
    localparam logic [7:0] ADCR_BGAP_RST = 8'h00;
    localparam logic [7:0] ADCR_BGAP_MASK = 8'h08;
    localparam int ADCR_START_BIT = 7;
    localparam int ADCR_BUSY_BIT = 6;
    localparam int ADCR_EN_BIT = 5;
    localparam int ADCR_FMT_BIT = 4;
    localparam int ADCR_GAIN0_BIT = 3;
    localparam int ADCR_GAIN1_BIT = 5;
    localparam int ADCR_BGEN_BIT = 3;
    localparam int ADCR_CONV_CLKS = 14;
    localparam int ADCR_RES_W = 10;

    typedef enum logic [2:0] {
        ADCR_IDLE = 3'h1,
        ADCR_CONV = 3'h2,
        ADCR_DONE = 3'h4
    } adcr_state_e;

    typedef struct packed {
        logic [1:0] source;
        logic [3:0] chan_onehot;
        logic [1:0] reference;
        logic [1:0] gain;
        logic [2:0] clk_div;
        logic conv_on;
        logic bandgap_on;
    } adcr_anactl_s;

    typedef struct packed {
        adcr_state_e state;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] bgap;
        logic [9:0] result;
        logic [7:0] prescale;
        logic [4:0] tick_cnt;
        logic ack;
        logic [31:0] rdata;
        logic irq;
    } adcr_state_s;
endpackage

// ### rtl/adcr_top.sv
// What this block does
// - Format 0: high holds 9..2, low top holds 1..0
// - Format 1: high low holds 9..8, low holds 7..0
// - Unused result bit positions read zero
// - Result bytes frozen while converter disabled
// - Start pulse begins conversion, sets busy
// - Busy clears one clock after result is stored
// - Busy bit is read only
// - Enable bit powers converter; none runs off
// - Two-bit gain code split across controls
// - Channel codes 0-3 connect, others float
// - Source field picks channel, amp, battery, supply
// - Reference field picks pin, supply, amp output
// - Converter clock is system clock over 2^code
// - Analog pin drops I/O function and pull-high
// - Bandgap on with low-voltage reset or bit
// - Bandgap control unused bits read zero
// - Completion pulses converter interrupt request
//
// Purpose: Converter control and result registers on classic Wishbone
// Assumes: Analog core returns SAMPLE_DATA valid at end of conversion
// Notes: Result mapping done at read time from one 10-bit store
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module adcr_top
    import adcr_pkg::*;
#(
    parameter int CONV_CLKS = ADCR_CONV_CLKS
) (
    // Clock and control
    input wire logic CLK,
    input wire logic SRST,
    input wire logic CE,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Analog core and system
    input wire logic [ADCR_RES_W-1:0] SAMPLE_DATA,
    input wire logic LOW_VOLTAGE_RESET_EN,
    input wire logic [3:0] ANALOG_PIN_SEL,
    output adcr_anactl_s ANA_CTRL,
    output logic CONV_CLK_TICK,
    output logic SAMPLE_STROBE,
    output logic [3:0] PIN_IO_DISABLE,
    output logic [3:0] PIN_PULLUP_DISABLE,
    output logic CONV_IRQ
);
    adcr_state_s s_r;
    adcr_state_s s_nxt;
    logic tick;
    logic wr;
    logic rd;
    logic [7:0] hi_byte;
    logic [7:0] lo_byte;
    logic [7:0] wbyte;

    // Divider tick: system clock over 2^code
    always_comb begin
        unique case (s_r.ctrl1[2:0])
            3'h0: tick = 1'b1;
            3'h1: tick = s_r.prescale[0:0] == 1'h1;
            3'h2: tick = s_r.prescale[1:0] == 2'h3;
            3'h3: tick = s_r.prescale[2:0] == 3'h7;
            3'h4: tick = s_r.prescale[3:0] == 4'hF;
            3'h5: tick = s_r.prescale[4:0] == 5'h1F;
            3'h6: tick = s_r.prescale[5:0] == 6'h3F;
            3'h7: tick = s_r.prescale[6:0] == 7'h7F;
        endcase
    end

    // Result byte layouts
    always_comb begin
        if (s_r.ctrl0[ADCR_FMT_BIT]) begin
            hi_byte = {6'h00, s_r.result[9:8]};
            lo_byte = s_r.result[7:0];
        end else begin
            hi_byte = s_r.result[9:2];
            lo_byte = {s_r.result[1:0], 6'h00};
        end
    end

    assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !s_r.ack && WB_SEL_I[0];
    assign rd = WB_CYC_I && WB_STB_I && !WB_WE_I && !s_r.ack;
    assign wbyte = WB_DAT_I[7:0];

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.irq = 1'b0;
        s_nxt.prescale = s_r.prescale + 8'h01;
        if (WB_CYC_I && WB_STB_I && !s_r.ack) begin
            s_nxt.ack = 1'b1;
        end
        // Sequencer first, so a trigger in the same cycle wins over completion
        unique case (s_r.state)
            ADCR_IDLE: ;
            ADCR_CONV: begin
                // Disabling mid-conversion aborts; result untouched
                if (!s_r.ctrl0[ADCR_EN_BIT]) begin
                    s_nxt.state = ADCR_IDLE;
                    s_nxt.ctrl0[ADCR_BUSY_BIT] = 1'b0;
                end else if (tick) begin
                    s_nxt.tick_cnt = s_r.tick_cnt + 5'h01;
                    if (s_r.tick_cnt == 5'(CONV_CLKS - 1)) begin
                        s_nxt.result = SAMPLE_DATA;
                        s_nxt.state = ADCR_DONE;
                    end
                end
            end
            ADCR_DONE: begin
                s_nxt.ctrl0[ADCR_BUSY_BIT] = 1'b0;
                s_nxt.irq = 1'b1;
                s_nxt.state = ADCR_IDLE;
            end
            default: s_nxt.state = ADCR_IDLE;
        endcase
        if (rd) begin
            unique case (WB_ADR_I)
                ADCR_OFS_RES_HI: s_nxt.rdata = {24'h000000, hi_byte};
                ADCR_OFS_RES_LO: s_nxt.rdata = {24'h000000, lo_byte};
                ADCR_OFS_CTRL0: s_nxt.rdata = {24'h000000, s_r.ctrl0};
                ADCR_OFS_CTRL1: s_nxt.rdata = {24'h000000, s_r.ctrl1};
                ADCR_OFS_BGAP: s_nxt.rdata = {24'h000000, s_r.bgap};
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end
        if (wr) begin
            unique case (WB_ADR_I)
                ADCR_OFS_CTRL0: begin
                    // Busy bit keeps hardware value
                    s_nxt.ctrl0 = {wbyte[7], s_nxt.ctrl0[ADCR_BUSY_BIT], wbyte[5:0]};
                    // Falling start write after high arms conversion
                    if (s_r.ctrl0[ADCR_START_BIT] && !wbyte[ADCR_START_BIT]
                        && s_r.ctrl0[ADCR_EN_BIT] && wbyte[ADCR_EN_BIT]) begin
                        s_nxt.ctrl0[ADCR_BUSY_BIT] = 1'b1;
                        s_nxt.state = ADCR_CONV;
                        s_nxt.tick_cnt = 5'h00;
                    end
                end
                ADCR_OFS_CTRL1: s_nxt.ctrl1 = wbyte;
                ADCR_OFS_BGAP: s_nxt.bgap = wbyte & ADCR_BGAP_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_r <= '{state: ADCR_IDLE, ctrl0: ADCR_CTRL0_RST, ctrl1: ADCR_CTRL1_RST,
                     bgap: ADCR_BGAP_RST, result: 10'h000, prescale: 8'h00,
                     tick_cnt: 5'h00, ack: 1'b0, rdata: 32'h00000000, irq: 1'b0};
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

    assign WB_DAT_O = s_r.rdata;
    assign WB_ACK_O = s_r.ack;
    assign CONV_IRQ = s_r.irq;
    assign CONV_CLK_TICK = tick && s_r.ctrl0[ADCR_EN_BIT];
    assign SAMPLE_STROBE = s_r.state == ADCR_DONE;

    // Analog steering decode
    always_comb begin
        ANA_CTRL.source = s_r.ctrl1[7:6];
        ANA_CTRL.chan_onehot = s_r.ctrl0[2] ? 4'h0 : 4'(4'h1 << s_r.ctrl0[1:0]);
        ANA_CTRL.reference = s_r.ctrl1[4:3];
        ANA_CTRL.gain = {s_r.ctrl1[ADCR_GAIN1_BIT], s_r.ctrl0[ADCR_GAIN0_BIT]};
        ANA_CTRL.clk_div = s_r.ctrl1[2:0];
        ANA_CTRL.conv_on = s_r.ctrl0[ADCR_EN_BIT];
        ANA_CTRL.bandgap_on = LOW_VOLTAGE_RESET_EN || s_r.bgap[ADCR_BGEN_BIT];
    end

    // Analog pins lose digital function and pull-high
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pin
            assign PIN_IO_DISABLE[g] = ANALOG_PIN_SEL[g];
            assign PIN_PULLUP_DISABLE[g] = ANALOG_PIN_SEL[g];
        end
    endgenerate
endmodule

// ### tb/adcr_top_assertions.sv
// Purpose: Port checks for adcr_top
// Assumes: CE held high by the bench
// Notes: One clock domain, so default clocking
`timescale 1ns/1ps
module adcr_top_assertions
    import adcr_pkg::*;
#(
    parameter int CONV_CLKS = 14
) (
    // Clock and bus
    input wire logic CLK,
    input wire logic SRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Analog side
    input wire logic LOW_VOLTAGE_RESET_EN,
    input wire logic [3:0] ANALOG_PIN_SEL,
    input wire adcr_anactl_s ANA_CTRL,
    input wire logic CONV_CLK_TICK,
    input wire logic [3:0] PIN_IO_DISABLE,
    input wire logic [3:0] PIN_PULLUP_DISABLE,
    input wire logic CONV_IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    sequence req_s; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
    sequence ack_s; WB_ACK_O ##1 !WB_ACK_O; endsequence
    ack_resp_a: assert property (req_s |=> ack_s) else $error("bus answer wrong");
    rd_upper_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
        else $error("upper read data set");
    io_off_a: assert property (PIN_IO_DISABLE == ANALOG_PIN_SEL)
        else $error("pin function kept");
    pull_off_a: assert property (PIN_PULLUP_DISABLE == ANALOG_PIN_SEL)
        else $error("pull-high kept");
    bgap_lvr_a: assert property (LOW_VOLTAGE_RESET_EN |-> ANA_CTRL.bandgap_on)
        else $error("bandgap off");
    chan_one_a: assert property ($onehot0(ANA_CTRL.chan_onehot))
        else $error("two channels on");
    tick_off_a: assert property (!ANA_CTRL.conv_on |-> !CONV_CLK_TICK)
        else $error("tick while off");
    tick_full_a: assert property (ANA_CTRL.conv_on && ANA_CTRL.clk_div == 3'h0 |-> CONV_CLK_TICK)
        else $error("undivided tick missing");
    irq_once_a: assert property (CONV_IRQ |=> !CONV_IRQ)
        else $error("irq too long");
endmodule

// ### tb/adcr_top_test.sv
// Purpose: Self-checking bench for adcr_top
// Assumes: CE tied high, short conversion count
// Notes: Reads are scored from a queue of expected words
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module adcr_top_test;
    import adcr_pkg::*;
    localparam int NC = 8;
    logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, low_voltage_reset = 0, ack, tick, strb, irq;
    logic [4:0] adr = 5'h00;
    logic [31:0] di = 32'h0, dout, ev;
    logic [9:0] sd = 10'h000, r10;
    logic [3:0] pin = 4'h0, iod, pud;
    logic [7:0] e0;
    adcr_anactl_s ac;
    logic [31:0] q[$];
    int mismatches = 0, cmp_count = 0, irqs = 0, strbs = 0, seed = 92559;
    always #10 clk = ~clk;
    adcr_top #(.CONV_CLKS(NC)) adcr_top_inst (.CLK(clk), .SRST(srst), .CE(1'b1),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(di), .WB_DAT_O(dout), .WB_ACK_O(ack), .SAMPLE_DATA(sd),
        .LOW_VOLTAGE_RESET_EN(low_voltage_reset), .ANALOG_PIN_SEL(pin), .ANA_CTRL(ac), .CONV_CLK_TICK(tick),
        .SAMPLE_STROBE(strb), .PIN_IO_DISABLE(iod), .PIN_PULLUP_DISABLE(pud), .CONV_IRQ(irq));
    task automatic complete_run;
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Holds the request until ack is seen; bounded so a dead slave ends the run
    task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        di <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin mismatches++; complete_run(); end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        q.push_back({24'h000000, e});
        wb(a, 1'b0, 8'h00);
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) begin
            ev = q.pop_front();
            `CHK(dout, ev)
        end
        if (irq === 1'b1) irqs++;
        if (strb === 1'b1) strbs++;
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd(ADCR_OFS_CTRL0, ADCR_CTRL0_RST);
        rd(ADCR_OFS_CTRL1, ADCR_CTRL1_RST);
        rd(ADCR_OFS_BGAP, ADCR_BGAP_RST);
        rd(ADCR_OFS_RES_HI, 8'h00);
        rd(5'h14, 8'h00);
        wb(ADCR_OFS_BGAP, 1'b1, 8'hFF);
        rd(ADCR_OFS_BGAP, 8'h08);
        `CHK(ac.bandgap_on, 1'b1)
        for (int c = 0; c < 8; c++) begin
            wb(ADCR_OFS_CTRL0, 1'b1, 8'(c));
            `CHK(ac.chan_onehot, c < 4 ? 4'(1 << c) : 4'h0)
        end
        for (int g = 0; g < 4; g++) begin
            e0 = (8'($random(seed)) & 8'hDF) | {2'h0, g[1], 5'h00};
            wb(ADCR_OFS_CTRL0, 1'b1, {4'h0, g[0], 3'h4});
            wb(ADCR_OFS_CTRL1, 1'b1, e0);
            rd(ADCR_OFS_CTRL1, e0);
            `CHK(ac.gain, 2'(g))
            `CHK({ac.source, ac.reference, ac.clk_div}, {e0[7:6], e0[4:0]})
        end
        // Undivided clock keeps the busy window inside the fixed wait
        wb(ADCR_OFS_CTRL1, 1'b1, 8'h00);
        for (int f = 0; f < 2; f++) begin
            sd <= 10'($random(seed));
            pin <= 4'($random(seed));
            low_voltage_reset <= f[0];
            e0 = {3'h1, 1'(f), 4'h4};
            wb(ADCR_OFS_CTRL0, 1'b1, e0 | 8'h80);
            wb(ADCR_OFS_CTRL0, 1'b1, e0);
            rd(ADCR_OFS_CTRL0, e0 | 8'h40);
            repeat (NC + 4) @(posedge clk);
            rd(ADCR_OFS_CTRL0, e0);
            rd(ADCR_OFS_RES_HI, f ? {6'h00, sd[9:8]} : sd[9:2]);
            rd(ADCR_OFS_RES_LO, f ? sd[7:0] : {sd[1:0], 6'h00});
        end
        `CHK(irqs, 2)
        `CHK(strbs, 2)
        r10 = sd;
        sd <= ~sd;
        wb(ADCR_OFS_CTRL0, 1'b1, 8'hC4);
        wb(ADCR_OFS_CTRL0, 1'b1, 8'h44);
        rd(ADCR_OFS_CTRL0, 8'h04);
        repeat (NC + 4) @(posedge clk);
        rd(ADCR_OFS_RES_HI, r10[9:2]);
        `CHK(irqs, 2)
        complete_run();
    end
endmodule
bind adcr_top adcr_top_assertions #(.CONV_CLKS(CONV_CLKS)) adcr_chk (.CLK(CLK), .SRST(SRST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .LOW_VOLTAGE_RESET_EN(LOW_VOLTAGE_RESET_EN), .ANALOG_PIN_SEL(ANALOG_PIN_SEL),
    .ANA_CTRL(ANA_CTRL), .CONV_CLK_TICK(CONV_CLK_TICK), .PIN_IO_DISABLE(PIN_IO_DISABLE),
    .PIN_PULLUP_DISABLE(PIN_PULLUP_DISABLE), .CONV_IRQ(CONV_IRQ));
